// >>> hdl/ltf_map.vh
// Register map, field positions, reset values and counts for the final training phase controller.
// Assumes inclusion by bare name from the controller source only.
`ifndef LTF_MAP_VH
`define LTF_MAP_VH
`define LTF_ADR_CTRL        8'h00
`define LTF_ADR_RETRY_CFG   8'h04
`define LTF_ADR_TIMER_CFG   8'h08
`define LTF_ADR_STATUS      8'h0C
`define LTF_ADR_EXCHANGE    8'h10
`define LTF_CTRL_AC_MODE    0
`define LTF_CTRL_DESKEW_MK  1
`define LTF_CTRL_FLOOD      2
`define LTF_CTRL_LOOPBACK   3
`define LTF_CTRL_RST        4'h1
`define LTF_RETRY_CFG_RST   32'h0000_0803
`define LTF_TIMER_CFG_RST   32'h0006_0100
`define LTF_STAT_INIT_DONE  16
`define LTF_STAT_LINK_FAIL  17
`define LTF_PATTERN_COUNT   4'h8
`define LTF_SKEW_ELECTRICAL 8'h04
`define LTF_SKEW_WIDE       8'h06
`define LTF_SKEW_LOOP_WIDE  8'h0B
`define LTF_SKEW_LOOP_CORE  8'h01
`define LTF_SCR_SEED        16'hFFFF
`define LTF_ST_T3           8'h01
`define LTF_ST_WAIT         8'h02
`define LTF_ST_OP           8'h04
`define LTF_ST_RETRY        8'h08
`define LTF_ST_T0           8'h10
`define LTF_ST_DISC         8'h20
`define LTF_ST_FLOOD        8'h40
`define LTF_ST_WARM         8'h80
`endif

// >>> hdl/ltf_train3.v
// Final training phase and operational state controller for one link endpoint, with a Wishbone slave.
// Assumes lane logic on sys_clk gives one-cycle event pulses; pins and link clock are asynchronous.
// Function
// - Final phase failure sends transmitter and every receiver lane back to first training state.
// - Transmitter already operational goes through retry-disconnect before first training state.
// - First state timer unchanged on fall-back unless short attempts exceeded.
// - Marker arrival spread beyond skew limit acts as timeout with zero first timer.
// - Deskew at pattern transition or on marker; optionally require marker on all lanes.
// - Transmitter may finish final phase under power stop, then tear down from wait or operation.
// - Receiver may go straight to disconnected together with the transmitter.
// - Final phase timer starts when transmitter or first receiver lane enters phase.
// - Receive FIFO read pointer starts only at the end-of-training marker.
// - FIFO skew tolerance at least six bit-times for wide links.
// - Loopback skew tolerance eleven bit-times plus one core clock.
// - In AC mode first characters in operation assume negative running disparity.
// - Send idles with ack pointer and credits, wait for peer's idles.
// - Replay history starting one past the peer's reported ack pointer.
// - Scrambler holds all-ones for first operational bit-time.
// - Link reset goes to warm reset; power stop goes to teardown state.
// - Local or received sync flood in operation floods every link.
// - Any received error in operation goes to retry-disconnect.
// - Disconnect idle followed by plain idle triggers retry-disconnect.
// - Two consecutive disconnect idles go to power stop teardown.
// - Early operational receiver retries at once; transmitter follows once it is in wait or operation.
// - First good CRC packet sets init complete and clears receive retry counter.
// - Send eight third phase patterns, one marker, then seed and enable scrambler.
// - Marker on any lane seeds descrambler, enables checks, accepts valid data.
//
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "ltf_map.vh"
module ltf_train3 (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        link_clk,
  input  wire        link_reset_in_n,
  input  wire        power_stop_input_n,
  input  wire        tx_t2_done,
  input  wire [3:0]  rx_lane_t3,
  input  wire        tx_symbol_done,
  input  wire [3:0]  rx_lane_marker,
  input  wire        rx_deskewed,
  input  wire        rx_error,
  input  wire        rx_idle_valid,
  input  wire        rx_idle_disc,
  input  wire [7:0]  rx_idle_ack_ptr,
  input  wire [7:0]  rx_idle_credits,
  input  wire        rx_good_crc,
  input  wire        flood_received,
  input  wire        retry_disc_done,
  output reg  [7:0]  tx_state,
  output reg  [7:0]  rx_state,
  output reg         tx_send_marker,
  output reg         tx_scr_load,
  output reg  [15:0] tx_scr_seed,
  output reg         tx_scr_en,
  output reg         tx_disp_neg,
  output reg         tx_send_idle,
  output reg         tx_replay_start,
  output reg  [7:0]  tx_replay_ptr,
  output reg         rx_descr_load,
  output reg         rx_check_en,
  output reg         rx_data_valid,
  output reg         rx_fifo_rd_start,
  output reg         first_timer_full,
  output reg         first_timer_zero,
  output reg         all_links_flood
);
  localparam LANES = 4;
  // Synchronisers: only the second stage is read by logic.
  reg  [2:0] sync_a;
  reg  [2:0] sync_b;
  reg        link_clk_d;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a     <= 3'h6;
      sync_b     <= 3'h6;
      link_clk_d <= 1'b0;
    end else begin
      sync_a     <= {power_stop_input_n, link_reset_in_n, link_clk};
      sync_b     <= sync_a;
      link_clk_d <= sync_b[0];
    end
  end
  wire link_edge = sync_b[0] & ~link_clk_d;
  wire reset_req = ~sync_b[1];
  wire pstop_req = ~sync_b[2];
  // Software registers.
  reg  [3:0]  ctrl;
  reg  [31:0] retry_cfg;
  reg  [31:0] timer_cfg;
  reg         init_done;
  reg         link_fail;
  reg  [3:0]  retry_cnt;
  reg  [3:0]  total_cnt;
  reg  [7:0]  rx_retries;
  reg  [7:0]  peer_credits;
  reg         flood_sw;
  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land at the edge where the master samples ack high, so the register changes with the answer.
  wire        wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire        clr_init = wb_wr & (wb_adr_i == `LTF_ADR_STATUS) & wb_sel_i[2] & wb_dat_i[`LTF_STAT_INIT_DONE];
  // Bus slave: ack one cycle after the strobe, unmapped reads return zero and writes are dropped.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0000_0000;
      ctrl      <= `LTF_CTRL_RST;
      retry_cfg <= `LTF_RETRY_CFG_RST;
      timer_cfg <= `LTF_TIMER_CFG_RST;
      flood_sw  <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      flood_sw <= 1'b0;
      if (wb_wr && wb_adr_i == `LTF_ADR_CTRL) begin
        ctrl     <= {wb_dat_i[3], 1'b0, wb_dat_i[1:0]};
        flood_sw <= wb_dat_i[`LTF_CTRL_FLOOD];
      end
      if (wb_wr && wb_adr_i == `LTF_ADR_RETRY_CFG)
        retry_cfg <= {20'h00000, wb_dat_i[11:8], 4'h0, wb_dat_i[3:0]};
      if (wb_wr && wb_adr_i == `LTF_ADR_TIMER_CFG)
        timer_cfg <= {8'h00, wb_dat_i[23:0]};
      case (wb_adr_i)
        `LTF_ADR_CTRL:      wb_dat_o <= {28'h0000000, ctrl};
        `LTF_ADR_RETRY_CFG: wb_dat_o <= retry_cfg;
        `LTF_ADR_TIMER_CFG: wb_dat_o <= timer_cfg;
        `LTF_ADR_STATUS:    wb_dat_o <= {14'h0000, link_fail, init_done, rx_state, tx_state};
        `LTF_ADR_EXCHANGE:  wb_dat_o <= {rx_retries, total_cnt, retry_cnt, peer_credits, tx_replay_ptr};
        default:            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
  // Per-lane marker capture with arrival stamp in link bit-times.
  reg  [15:0] phase_time;
  reg  [LANES-1:0] lane_seen;
  reg  [15:0] first_stamp;
  reg  [15:0] last_stamp;
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
          lane_seen[g] <= 1'b0;
        else if (rx_state != `LTF_ST_T3)
          lane_seen[g] <= 1'b0;
        else if (rx_lane_marker[g])
          lane_seen[g] <= 1'b1;
      end
    end
  endgenerate
  wire any_marker = |(rx_lane_marker & ~lane_seen);
  wire all_seen   = &(lane_seen | rx_lane_marker);
  // Skew limit never drops below the FIFO tolerance for wide or looped links.
  wire [7:0] skew_floor = ctrl[`LTF_CTRL_LOOPBACK] ? (`LTF_SKEW_LOOP_WIDE + `LTF_SKEW_LOOP_CORE) : `LTF_SKEW_WIDE;
  wire [7:0] skew_limit = (timer_cfg[23:16] > skew_floor) ? timer_cfg[23:16] : skew_floor;
  // A late lane is measured in its own arrival cycle, so with marker deskew the receiver cannot leave the phase before the last lane.
  wire [15:0] spread    = (any_marker ? phase_time : last_stamp) - first_stamp;
  wire skew_fail  = (rx_state == `LTF_ST_T3) & (|lane_seen) & (spread > {8'h00, skew_limit});
  wire in_t3      = (tx_state == `LTF_ST_T3) | (rx_state == `LTF_ST_T3);
  wire timeout    = in_t3 & (phase_time >= timer_cfg[15:0]);
  wire fallback   = (timeout | skew_fail) & ~reset_req;
  // Final phase timer runs from the first of transmitter or any receiver lane entering.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_time  <= 16'h0000;
      first_stamp <= 16'h0000;
      last_stamp  <= 16'h0000;
    end else begin
      if (!in_t3 || fallback)
        phase_time <= 16'h0000;
      else if (link_edge && phase_time != 16'hFFFF)
        phase_time <= phase_time + 16'h0001;
      if (rx_state == `LTF_ST_T3 && any_marker) begin
        if (lane_seen == {LANES{1'b0}})
          first_stamp <= phase_time;
        last_stamp <= phase_time;
      end else if (rx_state != `LTF_ST_T3) begin
        first_stamp <= 16'h0000;
        last_stamp  <= 16'h0000;
      end
    end
  end
  // Attempt bookkeeping on each fall-back; counters saturate so the limit test stays valid.
  wire short_over = (retry_cnt == 4'hF) | ((retry_cnt + 4'h1) > retry_cfg[3:0]);
  wire total_over = (total_cnt == 4'hF) | ((total_cnt + 4'h1) > retry_cfg[11:8]);
  wire give_up    = fallback & short_over & total_over;
  wire flood_now  = ((flood_sw | flood_received) & ((tx_state == `LTF_ST_OP) | (rx_state == `LTF_ST_OP))) | give_up;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      retry_cnt        <= 4'h0;
      total_cnt        <= 4'h0;
      rx_retries       <= 8'h00;
      first_timer_full <= 1'b0;
      first_timer_zero <= 1'b0;
      link_fail        <= 1'b0;
      init_done        <= 1'b0;
    end else begin
      if (fallback) begin
        if (retry_cnt != 4'hF) retry_cnt <= retry_cnt + 4'h1;
        if (total_cnt != 4'hF) total_cnt <= total_cnt + 4'h1;
        if (rx_retries != 8'hFF) rx_retries <= rx_retries + 8'h01;
        first_timer_zero <= skew_fail;
        if (short_over && !total_over)
          first_timer_full <= 1'b1;
        if (give_up)
          link_fail <= 1'b1;
      end else if (rx_good_crc && rx_state == `LTF_ST_OP) begin
        rx_retries       <= 8'h00;
        retry_cnt        <= 4'h0;
        first_timer_full <= 1'b0;
        first_timer_zero <= 1'b0;
      end
      // A good packet in the same cycle as a software clear keeps the flag set.
      if (rx_good_crc && rx_state == `LTF_ST_OP)
        init_done <= 1'b1;
      else if (clr_init)
        init_done <= 1'b0;
    end
  end
  // Transmitter sequencing: patterns, marker, scrambler seed, idle exchange and replay.
  reg  [3:0] pat_cnt;
  reg  [7:0] next_tx_state;
  reg        last_disc;
  wire       rx_retry_ev = rx_error | (rx_idle_valid & ~rx_idle_disc & last_disc);
  wire       rx_disc2    = rx_idle_valid & rx_idle_disc & last_disc;
  always @* begin
    next_tx_state = tx_state;
    case (tx_state)
      `LTF_ST_T0: if (tx_t2_done) next_tx_state = `LTF_ST_T3;
      `LTF_ST_T3: begin
        if (fallback) next_tx_state = `LTF_ST_T0;
        else if (tx_symbol_done && pat_cnt == `LTF_PATTERN_COUNT)
          next_tx_state = `LTF_ST_WAIT;
      end
      `LTF_ST_WAIT, `LTF_ST_OP: begin
        if (pstop_req) next_tx_state = `LTF_ST_DISC;
        else if (fallback) next_tx_state = `LTF_ST_RETRY;
        else if (rx_state == `LTF_ST_RETRY) next_tx_state = `LTF_ST_RETRY;
        else if (tx_state == `LTF_ST_WAIT && rx_idle_valid && !rx_idle_disc) next_tx_state = `LTF_ST_OP;
      end
      `LTF_ST_RETRY: if (retry_disc_done) next_tx_state = `LTF_ST_T0;
      `LTF_ST_DISC:  if (!pstop_req) next_tx_state = `LTF_ST_T0;
      `LTF_ST_WARM:  if (!reset_req) next_tx_state = `LTF_ST_T0;
      `LTF_ST_FLOOD: next_tx_state = `LTF_ST_FLOOD;
      default:       next_tx_state = `LTF_ST_T0;
    endcase
    if (flood_now && tx_state != `LTF_ST_WARM) next_tx_state = `LTF_ST_FLOOD;
    if (reset_req) next_tx_state = `LTF_ST_WARM;
  end
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state        <= `LTF_ST_T0;
      pat_cnt         <= 4'h0;
      tx_send_marker  <= 1'b0;
      tx_scr_load     <= 1'b0;
      tx_scr_seed     <= 16'h0000;
      tx_scr_en       <= 1'b0;
      tx_disp_neg     <= 1'b0;
      tx_send_idle    <= 1'b0;
      tx_replay_start <= 1'b0;
      tx_replay_ptr   <= 8'h00;
      peer_credits    <= 8'h00;
      all_links_flood <= 1'b0;
    end else begin
      tx_state        <= next_tx_state;
      tx_scr_load     <= 1'b0;
      tx_disp_neg     <= 1'b0;
      tx_replay_start <= 1'b0;
      if (tx_state == `LTF_ST_T3 && tx_symbol_done && pat_cnt != `LTF_PATTERN_COUNT)
        pat_cnt <= pat_cnt + 4'h1;
      else if (tx_state != `LTF_ST_T3)
        pat_cnt <= 4'h0;
      tx_send_marker <= (next_tx_state == `LTF_ST_T3) &
                        ((pat_cnt == `LTF_PATTERN_COUNT) | (tx_symbol_done & pat_cnt == `LTF_PATTERN_COUNT - 4'h1));
      if (tx_state == `LTF_ST_T3 && next_tx_state == `LTF_ST_WAIT) begin
        tx_scr_load <= 1'b1;
        tx_scr_seed <= `LTF_SCR_SEED;
        tx_scr_en   <= 1'b1;
        tx_disp_neg <= ctrl[`LTF_CTRL_AC_MODE];
      end else if (next_tx_state == `LTF_ST_T0 || next_tx_state == `LTF_ST_WARM) begin
        tx_scr_en <= 1'b0;
      end
      tx_send_idle <= (next_tx_state == `LTF_ST_WAIT);
      if (tx_state == `LTF_ST_WAIT && next_tx_state == `LTF_ST_OP) begin
        tx_replay_start <= 1'b1;
        tx_replay_ptr   <= rx_idle_ack_ptr + 8'h01;
        peer_credits    <= rx_idle_credits;
      end
      // The flood output stays set until a link reset clears it.
      if (next_tx_state == `LTF_ST_FLOOD)
        all_links_flood <= 1'b1;
      else if (reset_req)
        all_links_flood <= 1'b0;
    end
  end
  // Receiver sequencing: marker handling, deskew decision and operational exits.
  reg  [7:0] next_rx_state;
  wire       deskew_ok = ctrl[`LTF_CTRL_DESKEW_MK] ? all_seen : rx_deskewed;
  always @* begin
    next_rx_state = rx_state;
    case (rx_state)
      `LTF_ST_T0: if (|rx_lane_t3) next_rx_state = `LTF_ST_T3;
      `LTF_ST_T3: begin
        if (fallback) next_rx_state = `LTF_ST_T0;
        else if (pstop_req && next_tx_state == `LTF_ST_DISC) next_rx_state = `LTF_ST_DISC;
        else if ((rx_check_en | any_marker) && deskew_ok && !skew_fail) next_rx_state = `LTF_ST_OP;
      end
      `LTF_ST_OP: begin
        if (pstop_req || rx_disc2) next_rx_state = `LTF_ST_DISC;
        else if (rx_retry_ev || fallback) next_rx_state = `LTF_ST_RETRY;
      end
      `LTF_ST_RETRY: if (retry_disc_done) next_rx_state = `LTF_ST_T0;
      `LTF_ST_DISC:  if (!pstop_req) next_rx_state = `LTF_ST_T0;
      `LTF_ST_WARM:  if (!reset_req) next_rx_state = `LTF_ST_T0;
      `LTF_ST_FLOOD: next_rx_state = `LTF_ST_FLOOD;
      default:       next_rx_state = `LTF_ST_T0;
    endcase
    if (next_tx_state == `LTF_ST_DISC && rx_state != `LTF_ST_RETRY) next_rx_state = `LTF_ST_DISC;
    if (flood_now && rx_state != `LTF_ST_WARM) next_rx_state = `LTF_ST_FLOOD;
    if (reset_req) next_rx_state = `LTF_ST_WARM;
  end
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state         <= `LTF_ST_T0;
      rx_descr_load    <= 1'b0;
      rx_check_en      <= 1'b0;
      rx_data_valid    <= 1'b0;
      rx_fifo_rd_start <= 1'b0;
      last_disc        <= 1'b0;
    end else begin
      rx_state      <= next_rx_state;
      rx_descr_load <= 1'b0;
      if (rx_state == `LTF_ST_T3 && any_marker && !rx_check_en) begin
        rx_descr_load    <= 1'b1;
        rx_check_en      <= 1'b1;
        rx_data_valid    <= 1'b1;
        rx_fifo_rd_start <= 1'b1;
      end else if (next_rx_state != `LTF_ST_T3 && next_rx_state != `LTF_ST_OP) begin
        rx_check_en      <= 1'b0;
        rx_data_valid    <= 1'b0;
        rx_fifo_rd_start <= 1'b0;
      end
      if (rx_state != `LTF_ST_OP)
        last_disc <= 1'b0;
      else if (rx_idle_valid)
        last_disc <= rx_idle_disc;
    end
  end
endmodule // ltf_train3

// >>> sim/ltf_train3_properties.sv
// Concurrent checks on the ports of the final training phase controller.
// Assumes a bind onto ltf_train3; everything lives in the sys_clk domain.
`timescale 1ns/10ps
module ltf_train3_properties (
  input logic        sys_clk,
  input logic        arst_n,
  input logic        link_reset_in_n,
  input logic        tx_symbol_done,
  input logic [3:0]  rx_lane_marker,
  input logic        rx_error,
  input logic        rx_idle_valid,
  input logic        rx_idle_disc,
  input logic [7:0]  rx_idle_ack_ptr,
  input logic        flood_received,
  input logic [7:0]  tx_state,
  input logic [7:0]  rx_state,
  input logic        tx_send_marker,
  input logic        tx_scr_load,
  input logic [15:0] tx_scr_seed,
  input logic        tx_scr_en,
  input logic        tx_replay_start,
  input logic [7:0]  tx_replay_ptr,
  input logic        rx_descr_load,
  input logic        rx_check_en,
  input logic        rx_data_valid,
  input logic        rx_fifo_rd_start,
  input logic        all_links_flood
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  reg disc_seen;
  // Remembers whether the latest received idle carried the disconnect flag.
  always @(posedge sys_clk or negedge arst_n)
    if (!arst_n) disc_seen <= 1'b0;
    else if (rx_idle_valid) disc_seen <= rx_idle_disc;
  // The ninth symbol slot is the marker; the scrambler is seeded right after it.
  sequence s_last_sym;
    tx_state == 8'h01 && tx_send_marker && tx_symbol_done;
  endsequence
  sequence s_seeded;
    ##[0:2] tx_scr_load;
  endsequence
  a_last_marker: assert property (s_last_sym |=> tx_state == 8'h02 ##0 s_seeded) else $error("no seed after marker");
  a_seed_ones: assert property ($fell(tx_scr_load) |-> tx_scr_seed == 16'hFFFF && tx_scr_en) else $error("bad seed");
  a_replay_ptr: assert property (tx_state == 8'h02 && rx_state != 8'h08 && rx_idle_valid && !rx_idle_disc
    |=> tx_replay_start && tx_state == 8'h04 && tx_replay_ptr == $past(rx_idle_ack_ptr) + 8'h01)
    else $error("bad replay start");
  a_err_retry: assert property (rx_state == 8'h04 && rx_error && link_reset_in_n |=> ##[0:1] rx_state == 8'h08)
    else $error("error not retried");
  a_disc_plain: assert property (rx_state == 8'h04 && rx_idle_valid && !rx_idle_disc && disc_seen
    |=> ##[0:1] rx_state == 8'h08) else $error("disc then plain not retried");
  a_two_disc: assert property (rx_state == 8'h04 && rx_idle_valid && rx_idle_disc && disc_seen
    |=> ##[0:1] rx_state == 8'h20) else $error("two disc idles not torn down");
  a_rdptr_marker: assert property ($rose(rx_fifo_rd_start) |-> $past(|rx_lane_marker)) else $error("early read");
  a_marker_seed: assert property (rx_state == 8'h01 && |rx_lane_marker && !rx_check_en
    |=> rx_descr_load && rx_check_en && rx_data_valid) else $error("marker not acted on");
  a_flood_all: assert property (tx_state == 8'h04 && rx_state == 8'h04 && flood_received
    |=> ##[0:1] all_links_flood && tx_state == 8'h40) else $error("flood not entered");
  a_warm_reset: assert property ($fell(link_reset_in_n) |-> ##[2:4] tx_state == 8'h80 && rx_state == 8'h80)
    else $error("no warm reset");
  a_tx_follows: assert property (rx_state == 8'h08 && (tx_state == 8'h02 || tx_state == 8'h04)
    |=> ##[0:1] tx_state == 8'h08) else $error("tx did not follow");
endmodule // ltf_train3_properties
bind ltf_train3 ltf_train3_properties i_props (.*);

// >>> sim/ltf_peer.sv
// Behavioural peer endpoint as seen through the local receive lane logic.
// Assumes sys_clk paces events; the forwarded clock stands still while clk_on is low.
`timescale 1ns/10ps
module ltf_peer (
  input  logic       sys_clk,
  input  logic       clk_on,
  output logic       link_clk,
  output logic [3:0] rx_lane_marker,
  output logic       rx_error,
  output logic       rx_idle_valid,
  output logic       rx_idle_disc,
  output logic [7:0] rx_idle_ack_ptr,
  output logic [7:0] rx_idle_credits,
  output logic       rx_good_crc
);
  // Clock with an odd offset so its phase never lines up with sys_clk.
  initial begin
    link_clk = 1'b0;
    rx_lane_marker = 4'h0;
    rx_error = 1'b0;
    rx_good_crc = 1'b0;
    rx_idle_valid = 1'b0;
    rx_idle_disc = 1'b0;
    rx_idle_ack_ptr = 8'h00;
    rx_idle_credits = 8'h00;
    #7;
    forever #160 if (clk_on) link_clk = ~link_clk;
  end
  // Idles carry the ack pointer and credits; once released the fields show their inverse.
  task idle(input logic disc, input logic [7:0] ptr);
    @(posedge sys_clk);
    rx_idle_valid <= 1'b1;
    rx_idle_disc <= disc;
    rx_idle_ack_ptr <= ptr;
    rx_idle_credits <= 8'h20;
    @(posedge sys_clk);
    rx_idle_valid <= 1'b0;
    rx_idle_disc <= ~disc;
    rx_idle_ack_ptr <= ~ptr;
    rx_idle_credits <= 8'hDF;
  endtask
  task marker(input logic [3:0] m);
    @(posedge sys_clk);
    rx_lane_marker <= m;
    @(posedge sys_clk);
    rx_lane_marker <= 4'h0;
  endtask
  // One packet: with e high it is received in error, otherwise with a good CRC.
  task pkt(input logic e);
    @(posedge sys_clk);
    rx_error <= e;
    rx_good_crc <= ~e;
    @(posedge sys_clk);
    rx_error <= 1'b0;
    rx_good_crc <= 1'b0;
  endtask
endmodule // ltf_peer

// >>> sim/tb_top.sv
// Self-checking bench for the final training phase controller.
// Assumes the peer model in ltf_peer.sv and the checker bound from its own file.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
  logic        sys_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, link_clk, clk_on, seen_neg;
  logic [7:0]  wb_adr_i, rx_idle_ack_ptr, rx_idle_credits, tx_state, rx_state, tx_replay_ptr;
  logic [3:0]  wb_sel_i, rx_lane_t3, rx_lane_marker;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] tx_scr_seed;
  logic        link_reset_in_n, power_stop_input_n, tx_t2_done, tx_symbol_done, rx_deskewed, rx_error;
  logic        rx_idle_valid, rx_idle_disc, rx_good_crc, flood_received, retry_disc_done, tx_send_marker;
  logic        tx_scr_load, tx_scr_en, tx_disp_neg, tx_send_idle, tx_replay_start, rx_descr_load, rx_check_en;
  logic        rx_data_valid, rx_fifo_rd_start, first_timer_full, first_timer_zero, all_links_flood;
  logic [7:0]  radr [5] = '{8'h0C, 8'h00, 8'h04, 8'h08, 8'h14};
  logic [31:0] rexp [5] = '{32'h0000_1010, 32'h0000_0001, 32'h0000_0803, 32'h0006_0100, 32'h0};
  int          fails, n_checks, cycles;
  ltf_train3 i_dut (.*);
  ltf_peer i_peer (.*);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Cuts a hung run short; the tests need a few thousand cycles.
  always @(posedge sys_clk) begin
    cycles++;
    seen_neg <= (arst_n === 1'b1) && (seen_neg === 1'b1 || tx_disp_neg === 1'b1);
    if (cycles == 20000) begin
      fails++;
      finish_test;
    end
  end
  task finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Classic cycle: hold the request until ack is sampled, then release for a cycle.
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task sym;
    @(posedge sys_clk);
    tx_symbol_done <= 1'b1;
    @(posedge sys_clk);
    tx_symbol_done <= 1'b0;
  endtask
  task rst;
    @(posedge sys_clk);
    arst_n <= 1'b0;
    clk_on <= 1'b0;
    rx_deskewed <= 1'b0;
    step(3);
    arst_n <= 1'b1;
  endtask
  task enter;
    @(posedge sys_clk);
    tx_t2_done <= 1'b1;
    rx_lane_t3 <= 4'hF;
    clk_on <= 1'b1;
    @(posedge sys_clk);
    tx_t2_done <= 1'b0;
    rx_lane_t3 <= 4'h0;
    step(3);
    `CHK({tx_state, rx_state}, 16'h0101)
  endtask
  // Walks both directions from the final phase into operation.
  task train;
    enter;
    repeat (8) sym;
    step(2);
    `CHK(tx_send_marker, 1'b1)
    rx_deskewed <= 1'b1;
    i_peer.marker(4'hF);
    sym;
    step(4);
    `CHK({tx_state, tx_scr_en, tx_scr_seed, seen_neg, rx_check_en, rx_fifo_rd_start}, 28'h02FFFFF)
    `CHK(tx_send_idle, 1'b1)
    i_peer.idle(1'b0, 8'h41);
    step(2);
    `CHK({tx_state, rx_state, tx_replay_ptr}, 24'h040442)
  endtask
  initial begin
    {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, clk_on} = '0;
    {tx_t2_done, rx_lane_t3, tx_symbol_done, rx_deskewed, flood_received, retry_disc_done} = '0;
    {fails, n_checks, cycles} = '0;
    wb_sel_i = 4'hF;
    link_reset_in_n = 1'b1;
    power_stop_input_n = 1'b1;
    step(3);
    arst_n <= 1'b1;
    wb(1'b1, 8'h14, 32'hFFFF_FFFF);
    foreach (radr[i]) begin
      wb(1'b0, radr[i], 32'h0);
      `CHK(rd, rexp[i])
    end
    train;
    i_peer.pkt(1'b0);
    step(2);
    wb(1'b0, 8'h0C, 32'h0);
    `CHK(rd[16], 1'b1)
    i_peer.pkt(1'b1);
    step(3);
    `CHK({tx_state, rx_state}, 16'h0808)
    retry_disc_done <= 1'b1;
    @(posedge sys_clk);
    retry_disc_done <= 1'b0;
    step(2);
    `CHK({tx_state, rx_state}, 16'h1010)
    for (int k = 0; k < 2; k++) begin
      rst;
      train;
      i_peer.idle(1'b1, 8'h41);
      i_peer.idle(k[0], 8'h41);
      step(1);
      `CHK(rx_state, k ? 8'h20 : 8'h08)
    end
    rst;
    train;
    flood_received <= 1'b1;
    @(posedge sys_clk);
    flood_received <= 1'b0;
    step(3);
    `CHK({all_links_flood, tx_state}, 9'h140)
    rst;
    enter;
    power_stop_input_n <= 1'b0;
    repeat (9) sym;
    step(2);
    `CHK({tx_state, rx_state}, 16'h2020)
    power_stop_input_n <= 1'b1;
    rst;
    train;
    link_reset_in_n <= 1'b0;
    step(5);
    `CHK({tx_state, rx_state}, 16'h8080)
    link_reset_in_n <= 1'b1;
    rst;
    wb(1'b1, 8'h00, 32'h3);
    enter;
    i_peer.marker(4'h1);
    step(80);
    i_peer.marker(4'hE);
    step(6);
    `CHK({rx_state, first_timer_zero}, 9'h021)
    rst;
    wb(1'b1, 8'h08, 32'h0006_0010);
    enter;
    step(200);
    `CHK({tx_state, rx_state, first_timer_full}, 17'h02020)
    repeat (3) begin
      enter;
      step(200);
    end
    `CHK(first_timer_full, 1'b1)
    repeat (5) begin
      enter;
      step(200);
    end
    wb(1'b0, 8'h0C, 32'h0);
    `CHK({all_links_flood, rd[17]}, 2'b11)
    finish_test;
  end
endmodule // tb_top
